// *** bench/asf_remote.sv ***
// Remote serial station model: frames characters onto rxd and decodes txd
`timescale 1ns/1ns
module asf_remote (
    input wire logic mclk,
    input wire logic [7:0] bit_cyc,
    input wire logic txd,
    output logic rxd
);
    logic [7:0] got_q[$];

    // Line idles at the mark level between frames
    initial begin
        rxd = 1'b1;
    end

    // Start 0, data LSB first, optional parity, stop; a bad stop is allowed on request
    task automatic send_char(input logic [7:0] d, input logic with_par, input logic par,
                             input logic stop);
        logic [10:0] fr;
        int n;
        fr = with_par ? {stop, par, d, 1'b0} : {1'b1, stop, d, 1'b0};
        n = with_par ? 11 : 10;
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            rxd <= fr[i];
            repeat (bit_cyc - 8'h01) @(posedge mclk);
        end
        @(posedge mclk);
        rxd <= 1'b1;
    endtask

    // Samples each bit in its middle; parity is not used on the transmit path here
    always begin
        logic [7:0] d;
        @(negedge txd);
        repeat (bit_cyc / 8'h02) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge mclk);
            d[i] = txd;
        end
        repeat (bit_cyc) @(posedge mclk);
        got_q.push_back(d);
    end
endmodule

// *** bench/tb_async_serial_fifo_controller.sv ***
// Self-checking bench for the asynchronous serial FIFO controller
`timescale 1ns/1ns
module tb_async_serial_fifo_controller;
    logic mclk, arst_n, icm_wr, sec_timer_mode, timer_start, receive_clock_source;
    logic transmit_clock_source, parity_en, parity_odd, tx_wr, rx_rd, modem_status_rd;
    logic dsr, timer_status_rd, tx_ready_ff, dsr_level_ff, dsr_delta_ff, timer_exp_ff;
    logic irq_ff, rxd, txd_ff;
    logic [7:0] icm_data, ctrl_char_match_a, ctrl_char_match_b, tx_data, rx_data_ff, bit_cyc;
    logic [asf_pkg::BRG_W-1:0] bit_rate_gen_primary, bit_rate_gen_secondary;
    logic [4:0] rx_depth, rx_thresh, tx_thresh, int_enable, rx_level_ff, tx_level_ff;
    logic [3:0] rx_status_ff;
    logic [2:0] interrupt_ident_ff;
    logic [7:0] exp_q[$];
    logic [7:0] d;
    int seed, failures, total_checks;

    // Every port has a bench signal of the same name and width
    asf_uart #(.TMO_CYC(50)) DUT (.*);

    asf_remote u_rem (.mclk(mclk), .bit_cyc(bit_cyc), .txd(txd_ff), .rxd(rxd));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Waits, then steps past the edge so registered outputs have landed
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask

    task automatic strobe(input int k);
        @(posedge mclk);
        case (k)
            0: rx_rd <= 1'b1;
            1: icm_wr <= 1'b1;
            2: timer_start <= 1'b1;
            3: modem_status_rd <= 1'b1;
            default: timer_status_rd <= 1'b1;
        endcase
        @(posedge mclk);
        {icm_wr, timer_start, rx_rd, modem_status_rd, timer_status_rd} <= '0;
    endtask

    task automatic cmd(input logic [7:0] c);
        @(posedge mclk);
        icm_data <= c;
        strobe(1);
        wait_cyc(3);
    endtask

    function automatic logic [7:0] rnd_char();
        logic [31:0] r;
        r = $random(seed);
        return {1'b1, r[6:0]};
    endfunction

    task automatic rx_char(input logic [7:0] c, input logic bad_par, input logic stop);
        // Lets a format change made just before the call land first
        @(posedge mclk);
        u_rem.send_char(c, parity_en, (^c) ^ parity_odd ^ bad_par, stop);
        wait_cyc(6);
    endtask

    task automatic set_ie(input logic [4:0] v);
        @(posedge mclk);
        int_enable <= v;
    endtask

    initial begin
        repeat (30000) @(posedge mclk);
        failures++;
        report_and_stop();
    end

    initial begin
        seed = 32'hcd22;
        failures = 0;
        total_checks = 0;
        arst_n = 1'b0;
        {icm_wr, timer_start, tx_wr, rx_rd, modem_status_rd, timer_status_rd} = '0;
        {sec_timer_mode, receive_clock_source, transmit_clock_source} = '0;
        {parity_en, parity_odd, int_enable, rx_thresh, tx_thresh} = '0;
        {icm_data, tx_data} = '0;
        ctrl_char_match_a = 8'h1a;
        ctrl_char_match_b = 8'h13;
        bit_rate_gen_primary = 20'h00001;
        bit_rate_gen_secondary = 20'h00002;
        rx_depth = 5'h04;
        bit_cyc = 8'h10;
        dsr = 1'b1;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        wait_cyc(2);
        check("tx ready", tx_ready_ff, 1);
        check("txd idle", txd_ff, 1);
        check("masked irq", irq_ff, 0);
        check("dsr level", dsr_level_ff, 1);
        set_ie(5'h01 << asf_pkg::IE_TX);
        wait_cyc(2);
        check("tx ident", interrupt_ident_ff, asf_pkg::ID_TX);
        check("tx irq", irq_ff, 1);
        $display("test reset done");

        set_ie((5'h01 << asf_pkg::IE_RX) | (5'h01 << asf_pkg::IE_TX));
        d = rnd_char();
        rx_char(d, 1'b0, 1'b1);
        check("rx level", rx_level_ff, 1);
        check("rx ident", interrupt_ident_ff, asf_pkg::ID_RX);
        strobe(0);
        wait_cyc(2);
        check("rx data", rx_data_ff, d);
        check("rx level", rx_level_ff, 0);
        check("tx ident", interrupt_ident_ff, asf_pkg::ID_TX);
        for (int i = 0; i < 5; i++) begin
            exp_q.push_back(rnd_char());
            rx_char(exp_q[i], 1'b0, 1'b1);
        end
        check("rx full", rx_level_ff, 4);
        check("overrun", rx_status_ff[asf_pkg::ST_OVR], 1);
        for (int i = 0; i < 4; i++) begin
            strobe(0);
            wait_cyc(2);
            check("rx data", rx_data_ff, exp_q[i]);
        end
        exp_q.delete();
        $display("test receive done");

        set_ie(5'h01 << asf_pkg::IE_STAT);
        rx_depth <= 5'h00;
        for (int k = 0; k < 2; k++) begin
            cmd(asf_pkg::CMD_STAT_CLR);
            check("cleared", rx_status_ff, 0);
            rx_char(k == 0 ? ctrl_char_match_a : ctrl_char_match_b, 1'b0, 1'b1);
            check("match", rx_status_ff, 4'h1 << asf_pkg::ST_MATCH);
            check("stat ident", interrupt_ident_ff, asf_pkg::ID_STAT);
        end
        cmd(asf_pkg::CMD_STAT_CLR);
        parity_en <= 1'b1;
        parity_odd <= seed[3];
        rx_char(rnd_char(), 1'b0, 1'b1);
        check("good parity", rx_status_ff, 0);
        rx_char(rnd_char(), 1'b1, 1'b1);
        check("parity", rx_status_ff[asf_pkg::ST_PAR], 1);
        parity_en <= 1'b0;
        rx_char(rnd_char(), 1'b0, 1'b0);
        check("framing", rx_status_ff[asf_pkg::ST_FRM], 1);
        check("stat irq", irq_ff, 1);
        cmd(asf_pkg::CMD_STAT_CLR);
        check("cleared", rx_status_ff, 0);
        $display("test status done");

        cmd(asf_pkg::CMD_SW_RESET);
        check("soft rst lvl", rx_level_ff, 0);
        set_ie(5'h01 << asf_pkg::IE_TX);
        {receive_clock_source, transmit_clock_source} <= 2'b11;
        bit_cyc <= 8'h20;
        for (int i = 0; i < 18; i++) begin
            @(posedge mclk);
            d = rnd_char();
            tx_wr <= 1'b1;
            tx_data <= d;
            if (i < 17) exp_q.push_back(d);
        end
        @(posedge mclk);
        tx_wr <= 1'b0;
        wait_cyc(2);
        check("tx level", tx_level_ff, 16);
        check("tx full", tx_ready_ff, 0);
        check("tx irq off", irq_ff, 0);
        for (int i = 0; i < 8000 && tx_level_ff !== 5'h00; i++) @(posedge mclk);
        wait_cyc(700);
        check("tx count", u_rem.got_q.size(), 17);
        for (int i = 0; i < 17; i++) begin
            check("tx char", u_rem.got_q[i], exp_q[i]);
        end
        check("tx ident", interrupt_ident_ff, asf_pkg::ID_TX);
        $display("test transmit done");

        {receive_clock_source, transmit_clock_source} <= 2'b00;
        sec_timer_mode <= 1'b1;
        bit_rate_gen_secondary <= 20'h00014;
        set_ie(5'h01 << asf_pkg::IE_TMR);
        strobe(2);
        wait_cyc(10);
        check("timer early", timer_exp_ff, 0);
        wait_cyc(20);
        check("timer exp", timer_exp_ff, 1);
        check("tmr ident", interrupt_ident_ff, asf_pkg::ID_TMR);
        strobe(4);
        wait_cyc(2);
        check("timer clr", timer_exp_ff, 0);
        check("tmr irq", irq_ff, 0);
        $display("test timer done");

        set_ie(5'h01 << asf_pkg::IE_MDM);
        dsr <= 1'b0;
        wait_cyc(3);
        check("dsr level", dsr_level_ff, 0);
        check("dsr delta", dsr_delta_ff, 1);
        check("mdm ident", interrupt_ident_ff, asf_pkg::ID_MDM);
        strobe(3);
        wait_cyc(2);
        check("dsr ack", dsr_delta_ff, 0);
        check("mdm irq", irq_ff, 0);
        @(posedge mclk);
        dsr <= 1'b1;
        strobe(3);
        $display("test modem done");

        bit_cyc <= 8'h10;
        set_ie(5'h1f);
        rx_char(ctrl_char_match_a, 1'b0, 1'b1);
        check("prio", interrupt_ident_ff, asf_pkg::ID_RX);
        cmd(asf_pkg::CMD_SW_RESET);
        check("rst level", rx_level_ff, 0);
        check("rst status", rx_status_ff, 0);
        $display("test soft reset done");
        report_and_stop();
    end
endmodule

// *** logic/asf_brg.sv ***
// Rate generator: periodic tick divider or one-shot timeout timer
`timescale 1ns/1ns
module asf_brg #(
    parameter int CW = 20
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clr,
    input wire logic [CW-1:0] div,
    input wire logic timer_mode,
    input wire logic start,
    output logic tick,
    output logic expired
);
    logic [CW-1:0] cnt_ff;
    logic run_ff;
    wire at_zero = cnt_ff == '0;
    // Divide by zero behaves as divide by one
    wire [CW-1:0] reload = (div == '0) ? '0 : div - 1'b1;
    assign tick = !timer_mode && at_zero;
    assign expired = timer_mode && run_ff && at_zero;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
        end else if (clr) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
        end else if (timer_mode && start) begin
            cnt_ff <= reload;
            run_ff <= 1'b1;
        end else if (at_zero) begin
            cnt_ff <= timer_mode ? '0 : reload;
            run_ff <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    a_tick_gap: assert property (@(posedge mclk) disable iff (!arst_n) // RULE7
        tick && div > CW'(1) && !clr |=> !tick)
        else $error("rate tick repeated too early");
endmodule

// *** logic/asf_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides and a level count
`timescale 1ns/1ns
module asf_fifo #(
    parameter int W = 8,
    parameter int D = 16,
    parameter int LW = $clog2(D + 1)
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [LW-1:0] level
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [LW-1:0] cnt_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = cnt_ff != LW'(D);
    assign out_valid = cnt_ff != '0;
    assign out_data = mem[rp_ff];
    assign level = cnt_ff;

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        wrap_inc = (p == AW'(D - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_ff] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else if (clr) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= wrap_inc(wp_ff);
            end
            if (pop) begin
                rp_ff <= wrap_inc(rp_ff);
            end
            cnt_ff <= cnt_ff + LW'(push) - LW'(pop);
        end
    end
endmodule

// *** logic/asf_pkg.sv ***
// Shared constants and types for the asynchronous serial FIFO controller
package asf_pkg;
    localparam int DW = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int RX_DEPTH_DEF = 4;
    localparam int BRG_W = 20;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [3:0] FRAME_BITS_PAR = 4'hb;
    localparam logic [3:0] FRAME_BITS = 4'ha;
    localparam logic [3:0] DATA_BITS_PAR = 4'h9;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [7:0] CMD_STAT_CLR = 8'h04;
    localparam logic [7:0] CMD_SW_RESET = 8'h10;
    localparam int IE_RX = 0;
    localparam int IE_TX = 1;
    localparam int IE_STAT = 2;
    localparam int IE_TMR = 3;
    localparam int IE_MDM = 4;
    localparam int IE_W = 5;
    localparam int ST_PAR = 0;
    localparam int ST_FRM = 1;
    localparam int ST_OVR = 2;
    localparam int ST_MATCH = 3;
    localparam int ST_W = 4;
    localparam logic [2:0] ID_NONE = 3'h0;
    localparam logic [2:0] ID_RX = 3'h1;
    localparam logic [2:0] ID_TX = 3'h2;
    localparam logic [2:0] ID_STAT = 3'h3;
    localparam logic [2:0] ID_TMR = 3'h4;
    localparam logic [2:0] ID_MDM = 3'h5;
    localparam int CLK_NS = 10;
    localparam int TMO_NS = 7000000;
    localparam int TMO_CYC = TMO_NS / CLK_NS;
    typedef enum logic [1:0] {R_IDLE, R_START, R_BITS, R_STOP} asf_rx_t;
endpackage

// *** logic/asf_uart.sv ***
// Asynchronous serial controller with FIFOs, rate generators and interrupt steering
//
// Overview of operation
// (RULE1) Received char matching either control char flags status
// (RULE2) Enabled transmit interrupt fires while FIFO accepts; code fires only while transmit level is at or below tx_thresh
// (RULE3) Receive FIFO depth configurable, four supported
// (RULE4) Programmable thresholds; zero means one character interrupts
// (RULE5) Secondary generator runs as timeout timer
// (RULE6) Software selects receive and transmit clock sources
// (RULE7) Primary generator divides clock to bit rate
// (RULE8) Status-clear command clears all status
// (RULE9) Software reset command restores reset state; code leaves rx_data_ff holding the last character read
// (RULE10) Identification reports highest-priority pending source
// (RULE11) Level shows receive count; read removes one
// (RULE12) Level shows transmit count; write enqueues one
// (RULE13) Parity, framing, overrun flagged and raise status
// (RULE14) Status shows control character match occurred
// (RULE15) Modem line change interrupts; status read clears
// (RULE16) Modem must assert ready line; level reported
// (RULE17) Each interrupt source individually enabled
// (RULE18) Timer status read clears latched expiry
`timescale 1ns/1ns
module asf_uart #(
    parameter int TMO_CYC = asf_pkg::TMO_CYC,
    parameter int DEPTH = asf_pkg::FIFO_DEPTH,
    parameter int LW = $clog2(DEPTH + 1)
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic icm_wr,
    input wire logic [7:0] icm_data,
    input wire logic [7:0] ctrl_char_match_a,
    input wire logic [7:0] ctrl_char_match_b,
    input wire logic [asf_pkg::BRG_W-1:0] bit_rate_gen_primary,
    input wire logic [asf_pkg::BRG_W-1:0] bit_rate_gen_secondary,
    input wire logic sec_timer_mode,
    input wire logic timer_start,
    input wire logic receive_clock_source,
    input wire logic transmit_clock_source,
    input wire logic [LW-1:0] rx_depth,
    input wire logic [LW-1:0] rx_thresh,
    input wire logic [LW-1:0] tx_thresh,
    input wire logic [asf_pkg::IE_W-1:0] int_enable,
    input wire logic parity_en,
    input wire logic parity_odd,
    input wire logic tx_wr,
    input wire logic [7:0] tx_data,
    output logic tx_ready_ff,
    input wire logic rx_rd,
    output logic [7:0] rx_data_ff,
    output logic [LW-1:0] rx_level_ff,
    output logic [LW-1:0] tx_level_ff,
    output logic [asf_pkg::ST_W-1:0] rx_status_ff,
    input wire logic modem_status_rd,
    input wire logic dsr,
    output logic dsr_level_ff,
    output logic dsr_delta_ff,
    input wire logic timer_status_rd,
    output logic timer_exp_ff,
    output logic [2:0] interrupt_ident_ff,
    output logic irq_ff,
    input wire logic rxd,
    output logic txd_ff
);
    logic srst_ff;
    logic [3:0] tx_ov_ff;
    logic [3:0] tx_cnt_ff;
    logic [10:0] tx_sh_ff;
    logic tx_busy_ff;
    asf_pkg::asf_rx_t rx_st_ff;
    asf_pkg::asf_rx_t nxt_rx_st;
    logic [3:0] rx_ov_ff;
    logic [3:0] rx_cnt_ff;
    logic [8:0] rx_sh_ff;
    logic rx_done_ff;
    logic rx_ferr_ff;
    logic [LW-1:0] rx_lvl;
    logic [LW-1:0] tx_lvl;
    logic [7:0] rx_head;
    logic [7:0] tx_head;
    logic rx_valid;
    logic tx_valid;
    logic tx_in_ready;
    logic rx_in_ready;
    logic pri_tick;
    logic sec_tick;
    logic tmr_expire;

    // Command decode
    wire sw_rst = icm_wr && icm_data == asf_pkg::CMD_SW_RESET;
    wire clr_stat = icm_wr && icm_data == asf_pkg::CMD_STAT_CLR;

    // Clock source selection per direction
    wire rx_tick = receive_clock_source ? sec_tick : pri_tick; // RULE6
    wire tx_tick = transmit_clock_source ? sec_tick : pri_tick; // RULE6

    // Depth limit, zero or oversize falls back to the full buffer
    wire [LW-1:0] rx_lim = (rx_depth == '0 || rx_depth > LW'(DEPTH)) ? LW'(DEPTH) : rx_depth;
    wire rx_room = rx_lvl < rx_lim; // RULE3

    // Received character decode
    wire [7:0] rx_char = parity_en ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
    wire rx_perr = parity_en && ((^rx_sh_ff) != parity_odd);
    wire rx_match = rx_char == ctrl_char_match_a || rx_char == ctrl_char_match_b;
    wire rx_push = rx_done_ff && rx_room;
    wire rx_pop = rx_rd && rx_valid;

    // Transmit framing
    wire tx_load = !tx_busy_ff && tx_valid;
    wire tx_par = (^tx_head) ^ parity_odd;
    wire tx_step = tx_busy_ff && tx_tick && tx_ov_ff == asf_pkg::OVS_LAST;

    // Interrupt sources
    wire [asf_pkg::IE_W-1:0] pend = {dsr_delta_ff, timer_exp_ff, |rx_status_ff,
        tx_lvl <= tx_thresh, rx_lvl > rx_thresh}; // RULE2 RULE4 RULE13
    wire [asf_pkg::IE_W-1:0] act = pend & int_enable; // RULE17
    wire [2:0] nxt_ident = act[asf_pkg::IE_RX] ? asf_pkg::ID_RX :
        act[asf_pkg::IE_TX] ? asf_pkg::ID_TX :
        act[asf_pkg::IE_STAT] ? asf_pkg::ID_STAT :
        act[asf_pkg::IE_TMR] ? asf_pkg::ID_TMR :
        act[asf_pkg::IE_MDM] ? asf_pkg::ID_MDM : asf_pkg::ID_NONE; // RULE10

    wire [asf_pkg::ST_W-1:0] st_set = {rx_done_ff && rx_match, rx_done_ff && !rx_room,
        rx_done_ff && rx_ferr_ff, rx_done_ff && rx_perr}; // RULE1 RULE13 RULE14
    wire dsr_chg = dsr != dsr_level_ff; // RULE15

    // Timer load falls back to the default timeout when left at zero
    wire [asf_pkg::BRG_W-1:0] sec_load = (sec_timer_mode && bit_rate_gen_secondary == '0)
        ? asf_pkg::BRG_W'(TMO_CYC) : bit_rate_gen_secondary;

    asf_brg #(.CW(asf_pkg::BRG_W)) u_brg_pri (
        .mclk(mclk),
        .arst_n(arst_n),
        .clr(srst_ff),
        .div(bit_rate_gen_primary),
        .timer_mode(1'b0),
        .start(1'b0),
        .tick(pri_tick),
        .expired()
    ); // RULE7

    asf_brg #(.CW(asf_pkg::BRG_W)) u_brg_sec (
        .mclk(mclk),
        .arst_n(arst_n),
        .clr(srst_ff),
        .div(sec_load),
        .timer_mode(sec_timer_mode),
        .start(timer_start),
        .tick(sec_tick),
        .expired(tmr_expire)
    ); // RULE5

    asf_fifo #(.W(8), .D(DEPTH), .LW(LW)) u_tx_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .clr(srst_ff),
        .in_valid(tx_wr),
        .in_ready(tx_in_ready),
        .in_data(tx_data),
        .out_valid(tx_valid),
        .out_ready(tx_load),
        .out_data(tx_head),
        .level(tx_lvl)
    ); // RULE12

    asf_fifo #(.W(8), .D(DEPTH), .LW(LW)) u_rx_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .clr(srst_ff),
        .in_valid(rx_push),
        .in_ready(rx_in_ready),
        .in_data(rx_char),
        .out_valid(rx_valid),
        .out_ready(rx_rd),
        .out_data(rx_head),
        .level(rx_lvl)
    ); // RULE11

    // Receiver sequencing on the sixteen-times tick
    always_comb begin
        nxt_rx_st = rx_st_ff;
        if (rx_tick) begin
            unique case (rx_st_ff)
                asf_pkg::R_IDLE: if (!rxd) nxt_rx_st = asf_pkg::R_START;
                asf_pkg::R_START: if (rx_ov_ff == asf_pkg::OVS_MID) begin
                    nxt_rx_st = rxd ? asf_pkg::R_IDLE : asf_pkg::R_BITS;
                end
                asf_pkg::R_BITS: if (rx_ov_ff == asf_pkg::OVS_LAST && rx_cnt_ff ==
                    (parity_en ? asf_pkg::DATA_BITS_PAR : asf_pkg::DATA_BITS) - 4'h1) begin
                    nxt_rx_st = asf_pkg::R_STOP;
                end
                asf_pkg::R_STOP: if (rx_ov_ff == asf_pkg::OVS_LAST) nxt_rx_st = asf_pkg::R_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_st_ff <= asf_pkg::R_IDLE;
            rx_ov_ff <= 4'h0;
            rx_cnt_ff <= 4'h0;
            rx_sh_ff <= 9'h000;
            rx_done_ff <= 1'b0;
            rx_ferr_ff <= 1'b0;
        end else if (srst_ff) begin
            rx_st_ff <= asf_pkg::R_IDLE; // RULE9
            rx_ov_ff <= 4'h0;
            rx_cnt_ff <= 4'h0;
            rx_done_ff <= 1'b0;
        end else begin
            rx_st_ff <= nxt_rx_st;
            rx_done_ff <= rx_tick && rx_st_ff == asf_pkg::R_STOP && nxt_rx_st == asf_pkg::R_IDLE;
            if (rx_tick) begin
                // Midpoint alignment restarts the phase at the start bit centre
                rx_ov_ff <= (rx_st_ff != nxt_rx_st) ? 4'h0 : rx_ov_ff + 4'h1;
                if (rx_st_ff == asf_pkg::R_BITS && rx_ov_ff == asf_pkg::OVS_LAST) begin
                    rx_sh_ff <= {rxd, rx_sh_ff[8:1]};
                    rx_cnt_ff <= rx_cnt_ff + 4'h1;
                end
                if (rx_st_ff == asf_pkg::R_START) begin
                    rx_cnt_ff <= 4'h0;
                end
                if (rx_st_ff == asf_pkg::R_STOP && rx_ov_ff == asf_pkg::OVS_LAST) begin
                    rx_ferr_ff <= !rxd; // RULE13
                end
            end
        end
    end

    // Transmitter: start, data, optional parity, stop shifted LSB first
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_busy_ff <= 1'b0;
            tx_sh_ff <= 11'h7ff;
            tx_cnt_ff <= 4'h0;
            tx_ov_ff <= 4'h0;
            txd_ff <= 1'b1;
        end else if (srst_ff) begin
            tx_busy_ff <= 1'b0;
            tx_ov_ff <= 4'h0;
            txd_ff <= 1'b1;
        end else begin
            txd_ff <= tx_busy_ff ? tx_sh_ff[0] : 1'b1;
            if (tx_load) begin
                tx_busy_ff <= 1'b1;
                tx_ov_ff <= 4'h0;
                tx_sh_ff <= parity_en ? {1'b1, tx_par, tx_head, 1'b0}
                                      : {2'b11, tx_head, 1'b0};
                tx_cnt_ff <= parity_en ? asf_pkg::FRAME_BITS_PAR : asf_pkg::FRAME_BITS;
            end else if (tx_busy_ff && tx_tick) begin
                tx_ov_ff <= tx_ov_ff + 4'h1;
                if (tx_step) begin
                    tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
                    tx_cnt_ff <= tx_cnt_ff - 4'h1;
                    tx_busy_ff <= tx_cnt_ff != 4'h1;
                end
            end
        end
    end

    // Sticky status; a set in the clearing cycle survives
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            srst_ff <= 1'b0;
            rx_status_ff <= '0;
            timer_exp_ff <= 1'b0;
            dsr_delta_ff <= 1'b0;
            dsr_level_ff <= 1'b0;
        end else begin
            srst_ff <= sw_rst; // RULE9
            dsr_level_ff <= dsr; // RULE16
            rx_status_ff <= ((clr_stat || srst_ff) ? '0 : rx_status_ff) | st_set; // RULE8
            timer_exp_ff <= (timer_exp_ff && !clr_stat && !timer_status_rd && !srst_ff)
                || tmr_expire; // RULE5 RULE18
            dsr_delta_ff <= (dsr_delta_ff && !clr_stat && !modem_status_rd && !srst_ff)
                || dsr_chg; // RULE15
        end
    end

    // Registered host-facing view
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_data_ff <= 8'h00;
            rx_level_ff <= '0;
            tx_level_ff <= '0;
            tx_ready_ff <= 1'b0;
            interrupt_ident_ff <= asf_pkg::ID_NONE;
            irq_ff <= 1'b0;
        end else begin
            if (rx_pop) begin
                rx_data_ff <= rx_head; // RULE11
            end
            rx_level_ff <= rx_lvl; // RULE11
            tx_level_ff <= tx_lvl; // RULE12
            tx_ready_ff <= tx_in_ready;
            interrupt_ident_ff <= nxt_ident; // RULE10
            irq_ff <= |act; // RULE2
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    a_match_flag: assert property (rx_done_ff && rx_match |=> rx_status_ff[asf_pkg::ST_MATCH]) // RULE14
        else $error("control character match not flagged");
    a_tx_irq_now: assert property (int_enable[asf_pkg::IE_TX] && tx_lvl <= tx_thresh // RULE2
        |=> irq_ff && interrupt_ident_ff != asf_pkg::ID_NONE)
        else $error("transmit interrupt not raised");
    a_rx_thresh: assert property (int_enable[asf_pkg::IE_RX] && rx_lvl > rx_thresh // RULE4
        |=> interrupt_ident_ff == asf_pkg::ID_RX)
        else $error("receive threshold interrupt missing");
    a_depth_lim: assert property (rx_lvl <= rx_lim || $past(rx_lim) != rx_lim) // RULE3
        else $error("receive depth exceeded");
    a_stat_clear: assert property (clr_stat && st_set == '0 && !tmr_expire && !dsr_chg // RULE8
        |=> rx_status_ff == '0 && !timer_exp_ff && !dsr_delta_ff)
        else $error("status clear left a flag set");
    a_sw_reset: assert property (sw_rst |=> ##1 rx_lvl == '0 && tx_lvl == '0 && !tx_busy_ff) // RULE9
        else $error("software reset did not flush");
    a_rx_pop: assert property (rx_pop && !rx_push |=> rx_lvl == $past(rx_lvl) - 1'b1) // RULE11
        else $error("receive read did not remove one");
    a_tx_push: assert property (tx_wr && tx_in_ready && !tx_load // RULE12
        |=> tx_lvl == $past(tx_lvl) + 1'b1)
        else $error("transmit write did not enqueue");
    a_ovr_flag: assert property (rx_done_ff && !rx_room |=> rx_status_ff[asf_pkg::ST_OVR]) // RULE13
        else $error("overrun not flagged");
    a_timer_read: assert property (timer_status_rd && !tmr_expire |=> !timer_exp_ff) // RULE18
        else $error("timer status read did not clear");
    a_timer_exp: assert property (tmr_expire |=> timer_exp_ff) // RULE5
        else $error("timer expiry lost");
    a_modem_chg: assert property (dsr_chg |=> dsr_delta_ff ##1 dsr_level_ff == $past(dsr, 2)) // RULE15
        else $error("modem change not latched");
    a_mask_mdm: assert property (!int_enable[asf_pkg::IE_MDM] // RULE17
        |=> interrupt_ident_ff != asf_pkg::ID_MDM)
        else $error("masked modem source reported");
    a_prio_none: assert property (act == '0 |=> !irq_ff && interrupt_ident_ff == asf_pkg::ID_NONE) // RULE10
        else $error("interrupt without enabled source");
    a_clk_sel: assert property (receive_clock_source && rx_st_ff == asf_pkg::R_IDLE && !rxd // RULE6
        && !sec_tick && !srst_ff |=> rx_st_ff == asf_pkg::R_IDLE)
        else $error("receiver ran on unselected clock");

    c_rx_char: cover property (rx_push);
    c_tx_frame: cover property (tx_load ##[1:200] txd_ff == 1'b0);
    c_timer: cover property (tmr_expire);
    c_match: cover property (rx_done_ff && rx_match);
endmodule
